// >>> rtl/node_monitor_defs.svh
// Constants for the fieldbus node address and status monitor.
// Assumes a 200 MHz core clock.
`ifndef NODE_MONITOR_DEFS_SVH
`define NODE_MONITOR_DEFS_SVH

`define CLK_PERIOD_PS        5000
// Flash periods in ms: 0.5 Hz is 2000 ms, 2 Hz is 500 ms.
`define SLOW_PERIOD_MS       2000
`define FAST_PERIOD_MS       500
`define SLOW_HALF_CYCLES     ((`SLOW_PERIOD_MS * 64'd1000000000 / `CLK_PERIOD_PS) / 2)
`define FAST_HALF_CYCLES     ((`FAST_PERIOD_MS * 64'd1000000000 / `CLK_PERIOD_PS) / 2)

`define ADDR_W               7
`define ADDR_NONE            7'h00
`define ADDR_ALL             7'h7f
`define STORED_ADDR_RESET    7'h01

`define OFF_CTRL             8'h00
`define OFF_STATUS           8'h04
`define OFF_STORED_ADDR      8'h08
`define OFF_MON_TIME         8'h0c
`define OFF_FAULT_DELAY      8'h10
`define OFF_ACTIVE_ADDR      8'h14

`define CTRL_PROFILE_BIT     0
`define CTRL_NO_STOP_BIT     1
`define CTRL_RELOAD_BIT      2
`define CTRL_ACK_BIT         3

`define ST_FLAG_BIT          0
`define ST_ALARM_BIT         1
`define ST_FAULT_BIT         2
`define ST_QSTOP_BIT         3
`define ST_PROFILE_BIT       4

`define MON_TIME_RESET       32'h000f4240
`define FAULT_DELAY_RESET    32'h000f4240

`endif

// >>> rtl/node_monitor_pkg.sv
// Types for the fieldbus node address and status monitor.
// Assumes nothing beyond the defs header.
package node_monitor_pkg;
    typedef enum logic [4:0] {
        LED_OFF       = 5'h01,
        LED_GREEN     = 5'h02,
        LED_GREEN_SLW = 5'h04,
        LED_RED_SLW   = 5'h08,
        LED_RED_FAST  = 5'h10
    } led_mode_t;

    typedef enum logic [2:0] {
        MON_RUN   = 3'h1,
        MON_ALARM = 3'h2,
        MON_FAULT = 3'h4
    } mon_state_t;
endpackage

// >>> rtl/node_monitor.sv
// Node address resolution, identity select, LED status and telegram-loss supervision.
// Assumes status inputs from the bus engine on core_clk; switches arrive from pins.
//
// Functional notes
// - LED dark before cyclic exchange starts.
// - LED steady green during normal exchange.
// - Green 0.5 Hz flash when partly established.
// - Red 0.5 Hz flash on bad configuration.
// - Red 2 Hz flash when exchange interrupted.
// - Switch address is (high mod 8)*16 plus low.
// - Switches 0 or 127 use stored address.
// - Switch address 1..126 used, readback only.
// - Switch zero default defers to stored.
// - Profile select: 0 native, 1 neutral.
// - Profile change applies after reset or download; here reset clears the select to 0 and a reload write applies it at once.
// - After monitoring time set flag, raise alarm.
// - After further delay raise fault, quick stop.
// - Fault reaction can be set to none.
// - Fault acknowledgeable immediately, drive runs without bus.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "node_monitor_defs.svh"

module node_monitor (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  addr_switch_high,
    input  wire logic [3:0]  addr_switch_low,
    input  wire logic        cyclic_running,
    input  wire logic        cyclic_partial,
    input  wire logic        config_error,
    input  wire logic        cyclic_lost,
    input  wire logic        telegram_received,
    input  wire logic        download_done,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    output logic      [6:0]  station_address,
    output logic             identity_profile,
    output logic             bus_diag_led_green,
    output logic             bus_diag_led_red,
    output logic             telegram_loss_flag,
    output logic             telegram_loss_alarm,
    output logic             telegram_loss_fault,
    output logic             quick_stop_reaction
);

    // ==========================================================
    // Switch synchroniser
    logic [7:0] sw_meta;
    logic [7:0] sw_sync;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sw_meta <= 8'h00;
            sw_sync <= 8'h00;
        end
        else
        begin
            sw_meta <= {addr_switch_high, addr_switch_low};
            sw_sync <= sw_meta;
        end
    end

    // ==========================================================
    // Registers
    logic [6:0]  stored_station_address;
    logic        identity_profile_select;
    logic        no_stop_reaction;
    logic [31:0] loss_monitoring_time;
    logic [31:0] fault_delay_time;
    logic        ack_pulse;
    logic        reload_pulse;
    logic        reset_seen;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stored_station_address  <= `STORED_ADDR_RESET;
            identity_profile_select <= 1'b0;
            no_stop_reaction        <= 1'b0;
            loss_monitoring_time    <= `MON_TIME_RESET;
            fault_delay_time        <= `FAULT_DELAY_RESET;
        end
        else if (reg_write)
        begin
            if (hit(reg_addr, `OFF_CTRL))
            begin
                identity_profile_select <= reg_wdata[`CTRL_PROFILE_BIT];
                no_stop_reaction        <= reg_wdata[`CTRL_NO_STOP_BIT];
            end
            else if (hit(reg_addr, `OFF_STORED_ADDR))
            begin
                if (reg_wdata[6:0] != `ADDR_NONE && reg_wdata[6:0] != `ADDR_ALL)
                    stored_station_address <= reg_wdata[6:0];
            end
            else if (hit(reg_addr, `OFF_MON_TIME))
                loss_monitoring_time <= reg_wdata;
            else if (hit(reg_addr, `OFF_FAULT_DELAY))
                fault_delay_time <= reg_wdata;
        end
    end

    assign ack_pulse    = reg_write && hit(reg_addr, `OFF_CTRL) && reg_wdata[`CTRL_ACK_BIT];
    assign reload_pulse = reg_write && hit(reg_addr, `OFF_CTRL) && reg_wdata[`CTRL_RELOAD_BIT];

    // ==========================================================
    // Address resolution
    logic [6:0] switch_address;

    assign switch_address = {sw_sync[6:4], sw_sync[3:0]};

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            station_address <= `ADDR_NONE;
        else if (switch_address == `ADDR_NONE || switch_address == `ADDR_ALL)
            station_address <= stored_station_address;
        else
            station_address <= switch_address;
    end

    // ==========================================================
    // Identity profile
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reset_seen       <= 1'b0;
            identity_profile <= 1'b0;
        end
        else
        begin
            reset_seen <= 1'b1;
            if (reload_pulse)
                identity_profile <= reg_wdata[`CTRL_PROFILE_BIT];
            else if (!reset_seen || download_done)
                identity_profile <= identity_profile_select;
        end
    end

    // ==========================================================
    // Telegram-loss supervision
    node_monitor_pkg::mon_state_t mon_state;
    logic [31:0] loss_count;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mon_state           <= node_monitor_pkg::MON_RUN;
            loss_count          <= 32'h00000000;
            telegram_loss_flag  <= 1'b0;
            telegram_loss_alarm <= 1'b0;
            telegram_loss_fault <= 1'b0;
        end
        else
        begin
            case (mon_state)
                node_monitor_pkg::MON_RUN:
                begin
                    if (telegram_received || !cyclic_running && !cyclic_lost)
                        loss_count <= 32'h00000000;
                    else if (loss_count + 32'h00000001 >= loss_monitoring_time)
                    begin
                        loss_count          <= 32'h00000000;
                        telegram_loss_flag  <= 1'b1;
                        telegram_loss_alarm <= 1'b1;
                        mon_state           <= node_monitor_pkg::MON_ALARM;
                    end
                    else
                        loss_count <= loss_count + 32'h00000001;
                end
                node_monitor_pkg::MON_ALARM:
                begin
                    if (telegram_received)
                    begin
                        loss_count          <= 32'h00000000;
                        telegram_loss_flag  <= 1'b0;
                        telegram_loss_alarm <= 1'b0;
                        mon_state           <= node_monitor_pkg::MON_RUN;
                    end
                    else if (loss_count + 32'h00000001 >= fault_delay_time)
                    begin
                        telegram_loss_fault <= 1'b1;
                        mon_state           <= node_monitor_pkg::MON_FAULT;
                    end
                    else
                        loss_count <= loss_count + 32'h00000001;
                end
                node_monitor_pkg::MON_FAULT:
                begin
                    if (ack_pulse)
                    begin
                        loss_count          <= 32'h00000000;
                        telegram_loss_fault <= 1'b0;
                        telegram_loss_flag  <= 1'b0;
                        telegram_loss_alarm <= 1'b0;
                        mon_state           <= node_monitor_pkg::MON_RUN;
                    end
                end
                default:
                    mon_state <= node_monitor_pkg::MON_RUN;
            endcase
        end
    end

    assign quick_stop_reaction = telegram_loss_fault && !no_stop_reaction;

    // ==========================================================
    // LED flashing
    node_monitor_pkg::led_mode_t led_mode;
    logic [31:0] slow_count;
    logic [31:0] fast_count;
    logic        slow_phase;
    logic        fast_phase;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            slow_count <= 32'h00000000;
            fast_count <= 32'h00000000;
            slow_phase <= 1'b0;
            fast_phase <= 1'b0;
        end
        else
        begin
            if (slow_count == 32'(`SLOW_HALF_CYCLES - 1))
            begin
                slow_count <= 32'h00000000;
                slow_phase <= !slow_phase;
            end
            else
                slow_count <= slow_count + 32'h00000001;
            if (fast_count == 32'(`FAST_HALF_CYCLES - 1))
            begin
                fast_count <= 32'h00000000;
                fast_phase <= !fast_phase;
            end
            else
                fast_count <= fast_count + 32'h00000001;
        end
    end

    always_comb
    begin
        if (cyclic_lost || mon_state != node_monitor_pkg::MON_RUN)
            led_mode = node_monitor_pkg::LED_RED_FAST;
        else if (config_error)
            led_mode = node_monitor_pkg::LED_RED_SLW;
        else if (cyclic_partial)
            led_mode = node_monitor_pkg::LED_GREEN_SLW;
        else if (cyclic_running)
            led_mode = node_monitor_pkg::LED_GREEN;
        else
            led_mode = node_monitor_pkg::LED_OFF;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_diag_led_green <= 1'b0;
            bus_diag_led_red   <= 1'b0;
        end
        else
        begin
            case (led_mode)
                node_monitor_pkg::LED_GREEN:
                begin
                    bus_diag_led_green <= 1'b1;
                    bus_diag_led_red   <= 1'b0;
                end
                node_monitor_pkg::LED_GREEN_SLW:
                begin
                    bus_diag_led_green <= slow_phase;
                    bus_diag_led_red   <= 1'b0;
                end
                node_monitor_pkg::LED_RED_SLW:
                begin
                    bus_diag_led_green <= 1'b0;
                    bus_diag_led_red   <= slow_phase;
                end
                node_monitor_pkg::LED_RED_FAST:
                begin
                    bus_diag_led_green <= 1'b0;
                    bus_diag_led_red   <= fast_phase;
                end
                default:
                begin
                    bus_diag_led_green <= 1'b0;
                    bus_diag_led_red   <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 32'h00000000;
        else if (reg_read)
        begin
            if (hit(reg_addr, `OFF_CTRL))
                reg_rdata <= {30'h00000000, no_stop_reaction, identity_profile_select};
            else if (hit(reg_addr, `OFF_STATUS))
                reg_rdata <= {27'h0000000, identity_profile, quick_stop_reaction,
                              telegram_loss_fault, telegram_loss_alarm, telegram_loss_flag};
            else if (hit(reg_addr, `OFF_STORED_ADDR))
                reg_rdata <= {25'h0000000, station_address};
            else if (hit(reg_addr, `OFF_MON_TIME))
                reg_rdata <= loss_monitoring_time;
            else if (hit(reg_addr, `OFF_FAULT_DELAY))
                reg_rdata <= fault_delay_time;
            else if (hit(reg_addr, `OFF_ACTIVE_ADDR))
                reg_rdata <= {25'h0000000, station_address};
            else
                reg_rdata <= 32'h00000000;
        end
        else
            reg_rdata <= 32'h00000000;
    end

    // ==========================================================
    // Assertions
    // alarm follows flag
    flag_alarm_a: assert property (@(posedge core_clk) disable iff (!resetn)
        telegram_loss_flag == telegram_loss_alarm) else $error("flag and alarm differ");
    stop_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
        no_stop_reaction |-> !quick_stop_reaction) else $error("stop despite no-stop");
    fault_ack_a: assert property (@(posedge core_clk) disable iff (!resetn)
        telegram_loss_fault && ack_pulse |=> !telegram_loss_fault) else $error("ack ignored");
    led_dark_a: assert property (@(posedge core_clk) disable iff (!resetn)
        led_mode == node_monitor_pkg::LED_OFF |=> !bus_diag_led_green && !bus_diag_led_red)
        else $error("led lit while idle");
    led_green_a: assert property (@(posedge core_clk) disable iff (!resetn)
        led_mode == node_monitor_pkg::LED_GREEN |=> bus_diag_led_green)
        else $error("green not lit");
    addr_switch_a: assert property (@(posedge core_clk) disable iff (!resetn)
        switch_address != `ADDR_NONE && switch_address != `ADDR_ALL && $stable(switch_address)
        |=> station_address == $past(switch_address)) else $error("switch address lost");
    addr_stored_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (switch_address == `ADDR_NONE || switch_address == `ADDR_ALL)
        |=> station_address == $past(stored_station_address)) else $error("stored unused");
    profile_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
        reset_seen && !download_done && !reload_pulse |=> $stable(identity_profile))
        else $error("profile changed early");

endmodule

// >>> testbench/bus_master_model.sv
// Behavioural fieldbus master, seen through the bus engine status lines.
// Assumes the bench sets mode and send_en by non-blocking assignment; gap keeps its initial value.
`timescale 1ns/100ps

module bus_master_model (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic [2:0] mode,
    input  wire logic       send_en,
    input  wire logic [3:0] gap,
    output logic            cyclic_running,
    output logic            cyclic_partial,
    output logic            config_error,
    output logic            cyclic_lost,
    output logic            telegram_received
);
    logic [3:0] cnt;

    // ====================================================================
    // Exchange state: 1 running, 2 partial, 3 bad configuration, 4 lost.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cyclic_running <= 1'b0;
            cyclic_partial <= 1'b0;
            config_error   <= 1'b0;
            cyclic_lost    <= 1'b0;
        end
        else
        begin
            cyclic_running <= (mode == 3'h1);
            cyclic_partial <= (mode == 3'h2);
            config_error   <= (mode == 3'h3);
            cyclic_lost    <= (mode == 3'h4);
        end
    end

    // ====================================================================
    // One telegram pulse every gap plus one cycles while sending.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn || !send_en)
        begin
            cnt               <= 4'h0;
            telegram_received <= 1'b0;
        end
        else
        begin
            cnt               <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
            telegram_received <= (cnt >= gap);
        end
    end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the node address and status monitor.
// Assumes the master model drives the exchange status lines.
`timescale 1ns/100ps
`include "node_monitor_defs.svh"

module testbench;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  addr_switch_high = 4'h0;
    logic [3:0]  addr_switch_low = 4'h0;
    logic        download_done = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [2:0]  mode = 3'h0;
    logic        send_en = 1'b0;
    logic [3:0]  gap = 4'h3;
    logic [31:0] reg_rdata;
    logic [6:0]  station_address;
    logic        identity_profile, led_g, led_r, flag, alarm, fault, qstop;
    logic        run, part, cfg, lost, tel;
    logic [31:0] rd;
    int          mismatches = 0;
    int          total_checks = 0;
    int          seed = 49536;
    int          stored = 1;
    int          sw;
    int          wv;
    int          exp_addr;

    always #2.5 core_clk = ~core_clk;

    bus_master_model u_master (.core_clk(core_clk), .resetn(resetn), .mode(mode),
        .send_en(send_en), .gap(gap), .cyclic_running(run), .cyclic_partial(part),
        .config_error(cfg), .cyclic_lost(lost), .telegram_received(tel));

    node_monitor u_dut (.core_clk(core_clk), .resetn(resetn),
        .addr_switch_high(addr_switch_high), .addr_switch_low(addr_switch_low),
        .cyclic_running(run), .cyclic_partial(part), .config_error(cfg),
        .cyclic_lost(lost), .telegram_received(tel), .download_done(download_done),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .station_address(station_address),
        .identity_profile(identity_profile), .bus_diag_led_green(led_g),
        .bus_diag_led_red(led_r), .telegram_loss_flag(flag), .telegram_loss_alarm(alarm),
        .telegram_loss_fault(fault), .quick_stop_reaction(qstop));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    function automatic logic pick(input int k);
        pick = (k == 0) ? flag : fault;
    endfunction

    task automatic rise_within(input string name, input int k, input int lo, input int hi);
        int n;
        n = 0;
        while (pick(k) !== 1'b1 && n <= hi)
        begin
            tick(1);
            n++;
        end
        check(name, 32'(n >= lo && n <= hi), 32'h1);
    endtask

    task automatic close_out;
        $display("Checks made %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #50000;
        mismatches++;
        close_out();
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        tick(6);
        check("station_address", 32'(station_address), 32'h1);
        reg_rd(`OFF_MON_TIME, rd);
        check("mon_time", rd, `MON_TIME_RESET);
        reg_rd(`OFF_FAULT_DELAY, rd);
        check("fault_delay", rd, `FAULT_DELAY_RESET);
        reg_rd(8'h40, rd);
        check("unmapped", rd, 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            sw = (i == 0) ? 0 : (i == 1) ? 127 : (i == 2) ? 126 : ($random(seed) & 127);
            wv = $random(seed) & 127;
            reg_wr(`OFF_STORED_ADDR, 32'(wv));
            if (wv != 0 && wv != 127)
                stored = wv;
            @(posedge core_clk);
            addr_switch_high <= 4'(sw >> 4);
            addr_switch_low  <= 4'(sw & 15);
            tick(6);
            exp_addr = (sw == 0 || sw == 127) ? stored : sw;
            check("station_address", 32'(station_address), 32'(exp_addr));
            reg_rd(`OFF_STORED_ADDR, rd);
            check("address_readback", rd, 32'(exp_addr));
            reg_rd(`OFF_ACTIVE_ADDR, rd);
            check("active_address", rd, 32'(exp_addr));
        end
        reg_wr(`OFF_CTRL, 32'h1);
        tick(4);
        check("identity_profile", 32'(identity_profile), 32'h0);
        @(posedge core_clk);
        download_done <= 1'b1;
        @(posedge core_clk);
        download_done <= 1'b0;
        tick(2);
        check("identity_profile", 32'(identity_profile), 32'h1);
        reg_rd(`OFF_STATUS, rd);
        check("status_profile", rd & 32'h10, 32'h10);
        reg_wr(`OFF_CTRL, 32'h4);
        tick(3);
        check("identity_profile", 32'(identity_profile), 32'h0);
        for (int m = 0; m < 5; m++)
        begin
            @(posedge core_clk);
            mode    <= 3'(m);
            send_en <= (m == 1);
            tick(5);
            if (m != 2)
                check("led_green", 32'(led_g), 32'(m == 1));
            if (m <= 2)
                check("led_red", 32'(led_r), 32'h0);
        end
        reg_wr(`OFF_MON_TIME, 32'd10);
        reg_wr(`OFF_FAULT_DELAY, 32'd10);
        @(posedge core_clk);
        mode    <= 3'h1;
        send_en <= 1'b1;
        tick(40);
        check("loss_flag", 32'(flag), 32'h0);
        @(posedge core_clk);
        send_en <= 1'b0;
        rise_within("loss_flag", 0, 6, 14);
        check("loss_alarm", 32'(alarm), 32'h1);
        rise_within("loss_fault", 1, 8, 13);
        check("quick_stop", 32'(qstop), 32'h1);
        check("led_green", 32'(led_g), 32'h0);
        reg_rd(`OFF_STATUS, rd);
        check("status_fault", rd & 32'hc, 32'hc);
        @(posedge core_clk);
        mode <= 3'h0;
        reg_wr(`OFF_CTRL, 32'h8);
        tick(2);
        check("loss_fault", 32'(fault), 32'h0);
        check("quick_stop", 32'(qstop), 32'h0);
        tick(40);
        check("loss_fault", 32'(fault), 32'h0);
        reg_wr(`OFF_CTRL, 32'h2);
        @(posedge core_clk);
        mode <= 3'h1;
        rise_within("loss_fault", 1, 15, 26);
        check("quick_stop", 32'(qstop), 32'h0);
        close_out();
    end
endmodule
